// ==== rtl/gpr_defines.vh ====
// register offsets, field layout and reset values of the general-purpose pin block
`ifndef GPR_DEFINES_VH
`define GPR_DEFINES_VH

// ==========================================================================
// register offsets
`define GPR_ADDR_DIRECTION    7'h33
`define GPR_ADDR_OUTPUT_VALUE 7'h34
`define GPR_ADDR_INPUT_VALUE  7'h35

// ==========================================================================
// field layout and reset values
`define GPR_PIN_COUNT        12
`define GPR_PIN_MSB          11
`define GPR_RESERVED_MSB     15
`define GPR_RESERVED_LSB     12
`define GPR_RESERVED_ZERO    4'h0
`define GPR_DIRECTION_RESET  12'h000
`define GPR_OUTPUT_RESET     12'h000
`define GPR_READ_IDLE        16'h0000

`endif

// ==== rtl/gpr_pin_regs.v ====
// direction, output value and input registers for twelve general-purpose pins
//
// Behaviour
// - direction zero: pin is high-impedance input
// - direction one: pin driver enabled
// - output pin drives its output value bit
// - output value ignored on input pins
// - direction, output value read/write, reset zero
// - bits 15 to 12 reserved, read zero
// - input register read-only, writes ignored
// - output pin reads back driven value
`timescale 1ns/1ps
`include "gpr_defines.vh"

module gpr_pin_regs #(
  parameter ADDR_WIDTH = 7
) (
  input  wire                  I_CORE_CLK,
  input  wire                  I_RST_N,
  input  wire                  I_REG_WR,
  input  wire                  I_REG_RD,
  input  wire [ADDR_WIDTH-1:0] I_REG_ADDR,
  input  wire [15:0]           I_REG_WDATA,
  output reg  [15:0]           O_REG_RDATA,
  input  wire [11:0]           I_PIN,
  output reg  [11:0]           O_PIN,
  output reg  [11:0]           O_PIN_OE
);

  // ==========================================================================
  // reset release
  reg        rst_meta_q;
  reg        rst_n_q;

  always @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ==========================================================================
  // pin input synchroniser: a change counts once stages two and three agree
  // reset clears the chain, so the readback of input pins starts at zero
  wire [11:0] pin_level;
  genvar      g;

  generate
    for (g = 0; g < `GPR_PIN_COUNT; g = g + 1) begin : g_pin_sync
      reg  stage1_q;
      reg  stage2_q;
      reg  stage3_q;
      reg  level_q;
      wire level_d;

      // a level only counts once two later stages agree, so a metastable
      // first stage can never flip the readback by itself
      assign level_d = (stage2_q == stage3_q) ? stage3_q : level_q;

      always @(posedge I_CORE_CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
          stage1_q <= 1'b0;
          stage2_q <= 1'b0;
          stage3_q <= 1'b0;
          level_q  <= 1'b0;
        end else begin
          stage1_q <= I_PIN[g];
          stage2_q <= stage1_q;
          stage3_q <= stage2_q;
          level_q  <= level_d;
        end
      end

      assign pin_level[g] = level_q;
    end
  endgenerate

  // ==========================================================================
  // address decode
  // only the documented offsets decode; the address width alone does not widen the map
  // the input register address deliberately has no write enable: writes there vanish
  wire        sel_direction;
  wire        sel_output_value;
  wire        sel_input_value;
  wire        wr_direction;
  wire        wr_output_value;

  assign sel_direction    = (I_REG_ADDR == `GPR_ADDR_DIRECTION);
  assign sel_output_value = (I_REG_ADDR == `GPR_ADDR_OUTPUT_VALUE);
  assign sel_input_value  = (I_REG_ADDR == `GPR_ADDR_INPUT_VALUE);
  assign wr_direction     = I_REG_WR & sel_direction;
  assign wr_output_value  = I_REG_WR & sel_output_value;

  // ==========================================================================
  // software registers
  // reserved upper write bits are simply not stored, so a read can only show zeros there
  reg  [11:0] pin_direction_q;
  reg  [11:0] pin_direction_d;
  reg  [11:0] pin_output_value_q;
  reg  [11:0] pin_output_value_d;

  always @* begin
    pin_direction_d = pin_direction_q;
    if (wr_direction) begin
      pin_direction_d = I_REG_WDATA[`GPR_PIN_MSB:0];
    end
  end

  always @* begin
    pin_output_value_d = pin_output_value_q;
    if (wr_output_value) begin
      pin_output_value_d = I_REG_WDATA[`GPR_PIN_MSB:0];
    end
  end

  // both registers restart at zero so every pin comes up as a high-impedance input
  always @(posedge I_CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_direction_q <= `GPR_DIRECTION_RESET;
    end else begin
      pin_direction_q <= pin_direction_d;
    end
  end

  always @(posedge I_CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_output_value_q <= `GPR_OUTPUT_RESET;
    end else begin
      pin_output_value_q <= pin_output_value_d;
    end
  end

  // ==========================================================================
  // pin drivers
  reg  [11:0] pin_oe_d;
  reg  [11:0] pin_drive_d;

  always @* begin
    pin_oe_d = pin_direction_q;
  end

  always @* begin
    // masking keeps the pad data quiet on inputs whatever software stored
    pin_drive_d = pin_output_value_q & pin_direction_q;
  end

  // enable and data both come from flops, so the pad sees no decode glitch
  always @(posedge I_CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      O_PIN_OE <= 12'h000;
    end else begin
      O_PIN_OE <= pin_oe_d;
    end
  end

  always @(posedge I_CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      O_PIN <= 12'h000;
    end else begin
      O_PIN <= pin_drive_d;
    end
  end

  // ==========================================================================
  // input register source per pin
  // a pin driven against a stronger board level still reads its stored value
  wire [11:0] pin_input_value;

  generate
    for (g = 0; g < `GPR_PIN_COUNT; g = g + 1) begin : g_pin_readback
      // an output pin echoes what it drives, an input pin its synchronised level
      assign pin_input_value[g] = pin_direction_q[g] ? pin_output_value_q[g] :
                                  pin_level[g];
    end
  endgenerate

  // ==========================================================================
  // register words as software sees them
  wire [3:0]  reserved_bits;
  wire [15:0] direction_word;
  wire [15:0] output_value_word;
  wire [15:0] input_value_word;

  assign reserved_bits     = `GPR_RESERVED_ZERO;
  assign direction_word    = {reserved_bits, pin_direction_q};
  assign output_value_word = {reserved_bits, pin_output_value_q};
  assign input_value_word  = {reserved_bits, pin_input_value};

  // ==========================================================================
  // read path: read data valid one cycle after the strobe, held until the next read
  // a read in the same cycle as a write returns the old contents
  reg  [15:0] read_data_d;

  always @* begin
    read_data_d = O_REG_RDATA;
    if (I_REG_RD) begin
      if (sel_direction) begin
        read_data_d = direction_word;
      end else if (sel_output_value) begin
        read_data_d = output_value_word;
      end else if (sel_input_value) begin
        read_data_d = input_value_word;
      end else begin
        // unmapped addresses read as zero rather than holding stale data
        read_data_d = `GPR_READ_IDLE;
      end
    end
  end

  always @(posedge I_CORE_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      O_REG_RDATA <= `GPR_READ_IDLE;
    end else begin
      O_REG_RDATA <= read_data_d;
    end
  end

endmodule // gpr_pin_regs

// ==== verif/gpr_board.sv ====
// board side of the pins: a pin shows the device drive where enabled
`timescale 1ns/1ps
module gpr_board (input wire [11:0] i_d, i_e, i_b, output wire [11:0] o_l);
  assign o_l = (i_d & i_e) | (i_b & ~i_e);
endmodule // gpr_board

// ==== verif/gpr_chk_assertions.sv ====
// assertions on the pin register block ports
`timescale 1ns/1ps
module gpr_chk (input wire I_CORE_CLK, I_RST_N, I_REG_WR, I_REG_RD, input wire [6:0] I_REG_ADDR,
  input wire [15:0] I_REG_WDATA, O_REG_RDATA, input wire [11:0] I_PIN, O_PIN, O_PIN_OE);
  wire w33 = I_REG_WR && I_REG_ADDR == 7'h33;
  wire r35 = I_REG_RD && I_REG_ADDR == 7'h35;
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  chk_pin_gate: assert property (!(O_PIN & ~O_PIN_OE)) else $error("gate");
  chk_dir_oe: assert property (w33 ##1 !w33 |=> O_PIN_OE == $past(I_REG_WDATA[11:0], 2))
    else $error("dir");
  chk_oe_held: assert property (!w33 |-> ##2 $stable(O_PIN_OE)) else $error("held");
  chk_rd_rsvd: assert property (I_REG_RD |=> !O_REG_RDATA[15:12]) else $error("rsvd");
  chk_rd_hold: assert property (!I_REG_RD |=> $stable(O_REG_RDATA)) else $error("hold");
  chk_rd_unmap: assert property (I_REG_RD && I_REG_ADDR > 7'h35 |=> !O_REG_RDATA)
    else $error("unmap");
  // the echo must match the drive seen at the same edge as the read strobe
  chk_out_echo: assert property (r35 && !I_REG_WR && $past(!I_REG_WR)
    |=> !((O_REG_RDATA[11:0] ^ $past(O_PIN)) & $past(O_PIN_OE))) else $error("echo");
  chk_in_level: assert property (($stable(I_PIN) && !O_PIN_OE)[*6] ##0 (r35 && $past(!I_REG_WR))
    |=> O_REG_RDATA[11:0] == $past(I_PIN)) else $error("level");
  cover property (w33);
  cover property (r35 && O_PIN_OE);
  cover property (I_REG_WR && I_REG_RD);
endmodule // gpr_chk
bind gpr_pin_regs gpr_chk u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_REG_WR(I_REG_WR),
  .I_REG_RD(I_REG_RD), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
  .O_REG_RDATA(O_REG_RDATA), .I_PIN(I_PIN), .O_PIN(O_PIN), .O_PIN_OE(O_PIN_OE));

// ==== verif/tb_top.sv ====
// self-checking bench for the pin register block
`timescale 1ns/1ps
module tb_top;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0;
  logic [6:0]  addr = 0;
  logic [15:0] wdata = 0;
  wire  [15:0] rdata;
  wire  [11:0] pin, drv, oe;
  int          num_errors = 0, checks = 0;
  // row: write flag and address, write data, read seen, enables and drive after
  logic [63:0] rows [9] = '{64'hb3ffff0000fff000, 64'h3300000ffffff000, 64'hb4fc3c0000fffc3c,
    64'hb3ff0f0ffff0fc0c, 64'h3400000c3cf0fc0c, 64'hffffff0000f0fc0c, 64'hb5ffff0cacf0fc0c,
    64'h3500000cacf0fc0c, 64'hb300000f0f000000};
  gpr_pin_regs uut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REG_WR(wr), .I_REG_RD(rd),
    .I_REG_ADDR(addr), .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_PIN(pin), .O_PIN(drv),
    .O_PIN_OE(oe));
  gpr_board u_brd (.i_d(drv), .i_e(oe), .i_b(12'h5a3), .o_l(pin));
  initial forever #50 clk = ~clk;
  initial #12us close_out(1); // about twice the expected run
  task chk(input string n, input logic [23:0] s, x);
    checks++;
    num_errors += (s !== x);
    if (s !== x) $display("unexpected %s exp %h seen %h", n, x, s);
  endtask
  task acc(input logic w, input logic [6:0] a, input logic [15:0] d);
    {wr, rd, addr, wdata} = {w, 1'b1, a, d};
    @(negedge clk);
    {wr, rd} = 2'b00;
    @(negedge clk);
  endtask
  task close_out(input int late);
    $display("checks %0d errors %0d", checks, num_errors + late);
    if (num_errors + late == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    foreach (rows[i]) begin
      acc(rows[i][63], rows[i][62:56], rows[i][55:40]);
      chk("read", rdata, rows[i][39:24]);
      chk("pins", {oe, drv}, rows[i][23:0]);
    end
    repeat (8) @(negedge clk);
    acc(0, 7'h35, 0);
    chk("level", rdata, 16'h05a3);
    acc(1, 7'h33, 16'h00ff);
    acc(0, 7'h33, 0);
    chk("dir", rdata, 16'h00ff);
    chk("pins", {oe, drv}, 24'h0ff03c);
    rst_n = 0;
    @(negedge clk);
    chk("rst pins", {oe, drv}, 24'h0);
    chk("rst read", rdata, 24'h0);
    repeat (2) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    acc(0, 7'h34, 0);
    chk("rst out", rdata, 24'h0);
    chk("rst pins", {oe, drv}, 24'h0);
    close_out(0);
  end
endmodule // tb_top
